// ===== bench/residual_diff_front_end.sv
// Measurement front end and blocking matrix model
`timescale 1ns/1ps
module residual_diff_front_end (
  input wire logic i_clock,
  output logic o_sample,
  output logic o_block,
  output logic [9:0][19:0] o_ph
);
  initial begin
    o_sample = 1'b0;
    o_block = 1'b0;
    o_ph = '0;
  end

  // Block level change with no new phasor set
  task automatic hold_block(input logic blk, input int cycles);
    @(posedge i_clock);
    o_block <= blk;
    repeat (cycles) @(posedge i_clock);
  endtask : hold_block

  // Block settles one cycle ahead of the sample pulse
  task automatic present(input logic blk, input logic [9:0][19:0] ph);
    @(posedge i_clock);
    o_block <= blk;
    @(posedge i_clock);
    o_sample <= 1'b1;
    o_ph <= ph;
    @(posedge i_clock);
    o_sample <= 1'b0;
    // Stale phasors must not look valid
    o_ph <= ~ph;
  endtask : present
endmodule : residual_diff_front_end

// ===== bench/test_residual_diff_stage.sv
// Self-checking testbench for the residual differential stage
`timescale 1ns/1ps
`include "residual_diff_regs.svh"
module test_residual_diff_stage;
  import residual_diff_pkg::*;
  localparam int MS = 4;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd, ev_stamp;
  logic waitreq, sample, block, trip, blocked, ev_valid;
  logic [9:0][19:0] ph;
  logic [1:0] cond, ev_code;
  logic [1:0] ev_q[$];
  logic [31:0] st_q[$];
  int fails = 0;
  int total_checks = 0;
  int tc_ctl[9] = '{0, 8, 0, 4, 2, 2, 2, 2, 0};
  int tc_a[9] = '{3000, 3000, 3000, 3000, 20000, 20000, 40000, 40000, 40000};
  int tc_r1[9] = '{0, 3000, -3000, -3000, 1990, 2010, 6990, 7010, 2010};
  logic tc_trip[9] = '{1, 0, 0, 1, 0, 1, 0, 1, 1};
  logic [7:0] rst_adr[11] = '{`RD_CTRL, `RD_PICKUP, `RD_TP1, `RD_TP2, `RD_SL1, `RD_SL2,
    `RD_EV_MASK, `RD_TRIP_CNT, `RD_BLOCK_CNT, `RD_REC_NUM, 8'h60};
  logic [31:0] rst_val[11] = '{`CTRL_RST, `PICKUP_RST, `TP1_RST, `TP2_RST, `SL1_RST,
    `SL2_RST, `EV_MASK_RST, 32'h0, 32'h0, 32'h0, 32'h0};

  residual_diff_stage #(.MS_CYCLES(MS), .RECORDS(12)) u_residual_diff_stage (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_address(address), .i_read(read),
    .i_write(write), .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq),
    .i_sample(sample), .i_block(block), .i_setting_group(3'h2),
    .i_phase_a_re(ph[0]), .i_phase_a_im(ph[1]), .i_phase_b_re(ph[2]),
    .i_phase_b_im(ph[3]), .i_phase_c_re(ph[4]), .i_phase_c_im(ph[5]),
    .i_res_one_re(ph[6]), .i_res_one_im(ph[7]), .i_res_two_re(ph[8]),
    .i_res_two_im(ph[9]), .o_trip(trip), .o_blocked(blocked), .o_condition(cond),
    .o_event_valid(ev_valid), .o_event_code(ev_code), .o_event_stamp(ev_stamp)
  );

  residual_diff_front_end u_residual_diff_front_end (
    .i_clock(i_clock), .o_sample(sample), .o_block(block), .o_ph(ph)
  );

  initial begin
    forever #12.5 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    if (ev_valid === 1'b1) begin
      ev_q.push_back(ev_code);
      st_q.push_back(ev_stamp);
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge i_clock);
    address <= adr;
    read <= !wr;
    write <= wr;
    wdata <= dat;
    do begin
      @(posedge i_clock);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    rd = rdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) check("bus answer", 32'h1, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat);
  endtask : wr

  task automatic rdc(input string name, input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check(name, rd, exp);
  endtask : rdc

  // One processing cycle, then time for events and records to settle
  task automatic run(input logic blk, input int a, input int b, input int r1, input int r2);
    logic [9:0][19:0] p;
    p = '0;
    p[0] = 20'(a);
    p[2] = 20'(b);
    p[6] = 20'(r1);
    p[8] = 20'(r2);
    u_residual_diff_front_end.present(blk, p);
    repeat (8) @(posedge i_clock);
  endtask : run

  initial begin
    repeat (2) @(posedge i_clock);
    check("condition in reset", 32'(cond), 32'(cond_normal));
    i_arst_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rdc("reset value", rst_adr[i], rst_val[i]);
    end
    wr(8'h60, 32'hffffffff);
    rdc("unmapped", 8'h60, 32'h0);
    wr(`RD_STATUS, 32'hf);
    rdc("status read only", `RD_STATUS, 32'h0);
    $display("test reset values done");

    wr(`RD_CTRL, 32'h200);
    run(1'b0, 3000, 0, 0, 0);
    check("trip", 32'(trip), 32'h1);
    check("condition trip", 32'(cond), 32'(cond_trip));
    u_residual_diff_front_end.hold_block(1'b1, 6);
    check("trip held", 32'(trip), 32'h1);
    run(1'b1, 3000, 0, 0, 0);
    check("trip dropped", 32'(trip), 32'h0);
    check("first event", 32'(ev_q[0]), 32'(ev_trip_on));
    check("second event", 32'(ev_q[1]), 32'(ev_trip_off));
    check("stamp advances", 32'(st_q[1] > st_q[0]), 32'h1);
    rdc("trip count", `RD_TRIP_CNT, 32'h1);
    $display("test trip and late block done");

    run(1'b0, 0, 0, 0, 0);
    wr(`RD_CTRL, 32'h200);
    rdc("trip count clear", `RD_TRIP_CNT, 32'h0);
    rdc("block count clear", `RD_BLOCK_CNT, 32'h0);
    run(1'b1, 3000, 0, 0, 0);
    check("blocked", 32'(blocked), 32'h1);
    check("no trip", 32'(trip), 32'h0);
    check("condition blocked", 32'(cond), 32'(cond_blocked));
    rdc("block count", `RD_BLOCK_CNT, 32'h1);
    rdc("trip count kept", `RD_TRIP_CNT, 32'h0);
    $display("test early block done");

    for (int i = 0; i < 9; i++) begin
      wr(`RD_CTRL, 32'(tc_ctl[i]));
      run(1'b0, tc_a[i], (tc_a[i] >= 20000) ? -tc_a[i] : 0, tc_r1[i], 0);
      check("characteristic", 32'(trip), 32'(tc_trip[i]));
    end
    $display("test characteristic done");

    wr(`RD_CTRL, 32'h40);
    run(1'b0, 0, 0, 0, 0);
    check("force disabled", 32'(cond), 32'(cond_normal));
    wr(`RD_CTRL, 32'h50);
    run(1'b0, 0, 0, 0, 0);
    check("force enabled", 32'(cond), 32'(cond_blocked));
    $display("test forcing done");

    wr(`RD_CTRL, 32'h1);
    run(1'b0, 3000, 0, 0, 0);
    check("uncompensated", 32'(trip), 32'h1);
    wr(`RD_CTRL, 32'h101);
    run(1'b0, 3000, 0, 0, 0);
    check("compensated", 32'(trip), 32'h0);
    wr(`RD_CTRL, 32'h0);
    run(1'b0, 3000, 0, 0, 0);
    check("offset outside cable end", 32'(trip), 32'h1);
    $display("test compensation done");

    run(1'b0, 0, 0, 0, 0);
    wr(`RD_CTRL, 32'h200);
    for (int i = 0; i < 13; i++) begin
      run(1'b0, 3000, 0, 0, 0);
      run(1'b0, 0, 0, 0, 0);
    end
    rdc("record count", `RD_REC_NUM, 32'd12);
    rdc("trip count total", `RD_TRIP_CNT, 32'd13);
    $display("test records done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    tally_and_finish();
  end
endmodule : test_residual_diff_stage

// ===== hw/residual_diff_pkg.sv
// Types shared by the residual differential stage
package residual_diff_pkg;
  typedef enum logic [1:0] {cond_normal, cond_trip, cond_blocked} cond_e;
  typedef enum logic [1:0] {ev_trip_on, ev_trip_off, ev_block_on, ev_block_off} event_e;
  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0] event_id;
    logic [23:0] bias;
    logic [23:0] diff;
    logic [23:0] thr;
    logic [23:0] bias_max;
    logic [23:0] diff_max;
    logic [23:0] thr_max;
    logic [23:0] calc;
    logic [23:0] meas;
    logic [2:0] group;
  } record_s;
endpackage : residual_diff_pkg

// ===== hw/residual_diff_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RESIDUAL_DIFF_REGS_SVH
`define RESIDUAL_DIFF_REGS_SVH
`define RD_CTRL 8'h00
`define RD_PICKUP 8'h04
`define RD_TP1 8'h08
`define RD_TP2 8'h0c
`define RD_SL1 8'h10
`define RD_SL2 8'h14
`define RD_EV_MASK 8'h18
`define RD_STATUS 8'h1c
`define RD_TRIP_CNT 8'h20
`define RD_BLOCK_CNT 8'h24
`define RD_REC_SEL 8'h28
`define RD_REC_NUM 8'h2c
`define RD_REC_BASE 8'h30
`define RD_REC_LAST 8'h58
`define RD_TIME_MS 8'h5c
`define CTRL_CED 0
`define CTRL_BIAS_MAX 1
`define CTRL_IN_TWO 2
`define CTRL_SUBTRACT 3
`define CTRL_FORCE_EN 4
`define CTRL_FORCE_LO 5
`define CTRL_FORCE_HI 6
`define CTRL_COMP_CMD 8
`define CTRL_CNT_CLR 9
`define CTRL_RST 10'h000
`define PICKUP_RST 20'h003e8
`define TP1_RST 20'h02710
`define TP2_RST 20'h07530
`define SL1_RST 20'h003e8
`define SL2_RST 20'h00fa0
`define EV_MASK_RST 8'hff
`define SLOPE_DIV 10000
`define TIME_CLK_HZ 40000000
`define TIME_MS_CYCLES (`TIME_CLK_HZ / 1000)
`endif

// ===== hw/residual_diff_stage.sv
// Residual differential protection stage with Avalon-MM register slave
// Notes on behaviour
// - Differential vector is phase sum plus or minus the selected residual input.
// - Bias is average of calculated and measured residual, or maximum magnitude.
// - Threshold: base below turn one, first slope, then second slope plus full rise.
// - Block input sampled once at the start of each processing cycle.
// - Pick-up without block asserts trip.
// - Pick-up with block asserts blocked and nothing more.
// - Block arriving after trip drops trip and asserts blocked in its place while pick-up stays.
// - Subtract direction used when both transformers face the same way.
// - Add direction used when transformers face toward or away from each other.
// - Read-only condition shows normal, trip or blocked.
// - Two trip/block events, each with on and off store selection.
// - Every recorded event carries a time stamp.
// - Resettable cumulative counters of trips and of blocks.
// - Twelve newest records kept circularly, oldest overwritten on each on event.
// - Record holds stamp, event, bias, diff, threshold, maxima, residuals, group.
// - Compensation removes natural unbalance so settings may be more sensitive.
// - Compensate command stores an offset nulling calculated residual, cable end only.
// - Output status may be forced, only while forcing is enabled.
`timescale 1ns/1ps
`include "residual_diff_regs.svh"
module residual_diff_stage
  import residual_diff_pkg::*;
#(
  parameter int MS_CYCLES = `TIME_MS_CYCLES,
  parameter int RECORDS = 12
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_sample,
  input wire logic i_block,
  input wire logic [2:0] i_setting_group,
  input wire logic signed [19:0] i_phase_a_re,
  input wire logic signed [19:0] i_phase_a_im,
  input wire logic signed [19:0] i_phase_b_re,
  input wire logic signed [19:0] i_phase_b_im,
  input wire logic signed [19:0] i_phase_c_re,
  input wire logic signed [19:0] i_phase_c_im,
  input wire logic signed [19:0] i_res_one_re,
  input wire logic signed [19:0] i_res_one_im,
  input wire logic signed [19:0] i_res_two_re,
  input wire logic signed [19:0] i_res_two_im,
  output logic o_trip,
  output logic o_blocked,
  output logic [1:0] o_condition,
  output logic o_event_valid,
  output logic [1:0] o_event_code,
  output logic [31:0] o_event_stamp
);
  initial begin
    if (MS_CYCLES < 1 || RECORDS != 12) begin
      $error("residual_diff_stage: unsupported parameters");
    end
  end

  // Approximate magnitude: larger part plus half the smaller
  function automatic logic [23:0] mag(input logic signed [22:0] re, input logic signed [22:0] im);
    logic [22:0] ar;
    logic [22:0] ai;
    ar = re[22] ? 23'(-re) : 23'(re);
    ai = im[22] ? 23'(-im) : 23'(im);
    return (ar > ai) ? 24'(ar) + 24'(ai >> 1) : 24'(ai) + 24'(ar >> 1);
  endfunction : mag

  function automatic logic [23:0] umax(input logic [23:0] a, input logic [23:0] b);
    return (a > b) ? a : b;
  endfunction : umax

  function automatic logic [23:0] slope_rise(input logic [19:0] sl, input logic [23:0] span);
    logic [43:0] p;
    p = 44'(sl) * 44'(span);
    return 24'(p / 44'(`SLOPE_DIV));
  endfunction : slope_rise

  // Register file
  logic [9:0] ctrl_r;
  logic [19:0] pickup_r, tp1_r, tp2_r, sl1_r, sl2_r;
  logic [7:0] ev_mask_r;
  logic [3:0] rec_sel_r;
  logic comp_cmd_r, cnt_clr_r, req_done_r;
  wire logic req = (i_read | i_write) & o_waitrequest & ~req_done_r;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_waitrequest <= 1'b1;
      req_done_r <= 1'b0;
    end else begin
      o_waitrequest <= ~req;
      req_done_r <= req;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= `CTRL_RST;
      pickup_r <= `PICKUP_RST;
      tp1_r <= `TP1_RST;
      tp2_r <= `TP2_RST;
      sl1_r <= `SL1_RST;
      sl2_r <= `SL2_RST;
      ev_mask_r <= `EV_MASK_RST;
      rec_sel_r <= 4'h0;
      comp_cmd_r <= 1'b0;
      cnt_clr_r <= 1'b0;
    end else begin
      comp_cmd_r <= 1'b0;
      cnt_clr_r <= 1'b0;
      if (req && i_write) begin
        unique case (i_address)
          `RD_CTRL: begin
            ctrl_r <= {2'b00, i_writedata[7:0]};
            comp_cmd_r <= i_writedata[`CTRL_COMP_CMD];
            cnt_clr_r <= i_writedata[`CTRL_CNT_CLR];
          end
          `RD_PICKUP: pickup_r <= i_writedata[19:0];
          `RD_TP1: tp1_r <= i_writedata[19:0];
          `RD_TP2: tp2_r <= i_writedata[19:0];
          `RD_SL1: sl1_r <= i_writedata[19:0];
          `RD_SL2: sl2_r <= i_writedata[19:0];
          `RD_EV_MASK: ev_mask_r <= i_writedata[7:0];
          `RD_REC_SEL: rec_sel_r <= (i_writedata[3:0] < 4'(RECORDS)) ? i_writedata[3:0] : 4'h0;
          default: ;
        endcase
      end
    end
  end

  // Millisecond time base
  logic [31:0] ms_div_r, time_ms_r;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ms_div_r <= 32'h0;
      time_ms_r <= 32'h0;
    end else if (ms_div_r == 32'(MS_CYCLES - 1)) begin
      ms_div_r <= 32'h0;
      time_ms_r <= time_ms_r + 32'h1;
    end else begin
      ms_div_r <= ms_div_r + 32'h1;
    end
  end

  // Stage A: vector sums, block sample, compensation
  logic signed [22:0] calc_re, calc_im, off_re_r, off_im_r, cre_r, cim_r;
  logic signed [22:0] dre_r, dim_r, mre_r, mim_r;
  logic [23:0] pmax_r;
  logic block_s_r, valid_a_r;
  always_comb begin
    calc_re = 23'(i_phase_a_re) + 23'(i_phase_b_re) + 23'(i_phase_c_re);
    calc_im = 23'(i_phase_a_im) + 23'(i_phase_b_im) + 23'(i_phase_c_im);
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      off_re_r <= 23'h0;
      off_im_r <= 23'h0;
    end else if (comp_cmd_r && pmax_r != 24'h0) begin
      // Captured value already carries the old offset in cable end mode
      off_re_r <= ctrl_r[`CTRL_CED] ? off_re_r - cre_r : -cre_r;
      off_im_r <= ctrl_r[`CTRL_CED] ? off_im_r - cim_r : -cim_r;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {cre_r, cim_r, dre_r, dim_r, mre_r, mim_r} <= '0;
      pmax_r <= 24'h0;
      block_s_r <= 1'b0;
      valid_a_r <= 1'b0;
    end else begin
      valid_a_r <= i_sample;
      if (i_sample) begin
        logic signed [22:0] cr, ci, mr, mi;
        cr = ctrl_r[`CTRL_CED] ? calc_re + off_re_r : calc_re;
        ci = ctrl_r[`CTRL_CED] ? calc_im + off_im_r : calc_im;
        mr = ctrl_r[`CTRL_IN_TWO] ? 23'(i_res_two_re) : 23'(i_res_one_re);
        mi = ctrl_r[`CTRL_IN_TWO] ? 23'(i_res_two_im) : 23'(i_res_one_im);
        block_s_r <= i_block;
        cre_r <= cr;
        cim_r <= ci;
        mre_r <= mr;
        mim_r <= mi;
        // Subtract for same-facing transformers, add otherwise
        dre_r <= ctrl_r[`CTRL_SUBTRACT] ? cr - mr : cr + mr;
        dim_r <= ctrl_r[`CTRL_SUBTRACT] ? ci - mi : ci + mi;
        pmax_r <= umax(umax(mag(23'(i_phase_a_re), 23'(i_phase_a_im)),
                            mag(23'(i_phase_b_re), 23'(i_phase_b_im))),
                       mag(23'(i_phase_c_re), 23'(i_phase_c_im)));
      end
    end
  end

  // Stage B: bias, threshold, pick-up and outputs
  logic [23:0] calc_mag, meas_mag, diff_mag, bias, thr;
  logic [24:0] bias_sum;
  logic pick;
  always_comb begin
    calc_mag = mag(cre_r, cim_r);
    meas_mag = mag(mre_r, mim_r);
    diff_mag = mag(dre_r, dim_r);
    bias_sum = 25'(calc_mag) + 25'(meas_mag);
    bias = ctrl_r[`CTRL_BIAS_MAX] ? umax(pmax_r, meas_mag) : bias_sum[24:1];
    if (bias < 24'(tp1_r)) begin
      thr = 24'(pickup_r);
    end else if (bias <= 24'(tp2_r)) begin
      thr = 24'(pickup_r) + slope_rise(sl1_r, bias - 24'(tp1_r));
    end else begin
      thr = 24'(pickup_r) + slope_rise(sl2_r, bias - 24'(tp2_r))
            + slope_rise(sl1_r, 24'(tp2_r) - 24'(tp1_r));
    end
    pick = diff_mag > thr;
  end

  logic [23:0] bias_r, diff_r, thr_r, calc_r, meas_r, bmax_r, dmax_r, tmax_r;
  logic pick_r;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_trip <= 1'b0;
      o_blocked <= 1'b0;
      o_condition <= 2'(cond_normal);
      pick_r <= 1'b0;
      {bias_r, diff_r, thr_r, calc_r, meas_r, bmax_r, dmax_r, tmax_r} <= '0;
    end else if (valid_a_r) begin
      if (ctrl_r[`CTRL_FORCE_EN]) begin
        o_trip <= ctrl_r[`CTRL_FORCE_HI:`CTRL_FORCE_LO] == 2'(cond_trip);
        o_blocked <= ctrl_r[`CTRL_FORCE_HI:`CTRL_FORCE_LO] == 2'(cond_blocked);
        o_condition <= ctrl_r[`CTRL_FORCE_HI:`CTRL_FORCE_LO];
      end else begin
        o_trip <= pick & ~block_s_r;
        o_blocked <= pick & block_s_r;
        o_condition <= !pick ? 2'(cond_normal) : block_s_r ? 2'(cond_blocked) : 2'(cond_trip);
      end
      pick_r <= pick;
      bias_r <= bias;
      diff_r <= diff_mag;
      thr_r <= thr;
      calc_r <= calc_mag;
      meas_r <= meas_mag;
      bmax_r <= pick_r ? umax(bmax_r, bias) : bias;
      dmax_r <= pick_r ? umax(dmax_r, diff_mag) : diff_mag;
      tmax_r <= pick_r ? umax(tmax_r, thr) : thr;
    end
  end

  // Events, counters and records
  logic trip_d_r, blocked_d_r;
  logic [3:0] ev_pend_r, ev_new, ev_send;
  logic [15:0] trip_cnt_r, block_cnt_r;
  always_comb begin
    ev_new = {blocked_d_r & ~o_blocked, o_blocked & ~blocked_d_r,
              trip_d_r & ~o_trip, o_trip & ~trip_d_r};
    ev_send = 4'h0;
    for (int k = 0; k < 4; k++) begin
      if (ev_pend_r[k] && ev_send == 4'h0) ev_send[k] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trip_d_r <= 1'b0;
      blocked_d_r <= 1'b0;
      ev_pend_r <= 4'h0;
      o_event_valid <= 1'b0;
      o_event_code <= 2'h0;
      o_event_stamp <= 32'h0;
    end else begin
      trip_d_r <= o_trip;
      blocked_d_r <= o_blocked;
      // Bit 2k stores the on event, bit 2k+1 the off event
      ev_pend_r <= (ev_pend_r & ~ev_send) | (ev_new & ev_mask_r[3:0]);
      o_event_valid <= ev_send != 4'h0;
      o_event_code <= ev_send[1] ? 2'(ev_trip_off) : ev_send[2] ? 2'(ev_block_on)
                      : ev_send[3] ? 2'(ev_block_off) : 2'(ev_trip_on);
      o_event_stamp <= time_ms_r;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trip_cnt_r <= 16'h0;
      block_cnt_r <= 16'h0;
    end else begin
      // A count arriving with a clear is kept
      trip_cnt_r <= (cnt_clr_r ? 16'h0 : trip_cnt_r) + 16'(ev_new[0]);
      block_cnt_r <= (cnt_clr_r ? 16'h0 : block_cnt_r) + 16'(ev_new[2]);
    end
  end

  record_s rec_mem [RECORDS];
  logic [3:0] rec_head_r, rec_num_r, rec_rd_idx;
  record_s rec_rd;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rec_head_r <= 4'h0;
      rec_num_r <= 4'h0;
    end else if (ev_new[0] || ev_new[2]) begin
      rec_head_r <= (rec_head_r == 4'(RECORDS - 1)) ? 4'h0 : rec_head_r + 4'h1;
      if (rec_num_r != 4'(RECORDS)) rec_num_r <= rec_num_r + 4'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (ev_new[0] || ev_new[2]) begin
      rec_mem[rec_head_r] <= '{stamp: time_ms_r,
                               event_id: ev_new[0] ? 2'(ev_trip_on) : 2'(ev_block_on),
                               bias: bias_r, diff: diff_r, thr: thr_r,
                               bias_max: bmax_r, diff_max: dmax_r, thr_max: tmax_r,
                               calc: calc_r, meas: meas_r, group: i_setting_group};
    end
  end

  always_comb begin
    rec_rd_idx = (rec_head_r > rec_sel_r) ? rec_head_r - rec_sel_r - 4'h1
                 : rec_head_r + 4'(RECORDS) - rec_sel_r - 4'h1;
    rec_rd = rec_mem[rec_rd_idx];
  end

  // Read data path
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_readdata <= 32'h0;
    end else if (req && i_read) begin
      unique case (i_address)
        `RD_CTRL: o_readdata <= {22'h0, ctrl_r};
        `RD_PICKUP: o_readdata <= {12'h0, pickup_r};
        `RD_TP1: o_readdata <= {12'h0, tp1_r};
        `RD_TP2: o_readdata <= {12'h0, tp2_r};
        `RD_SL1: o_readdata <= {12'h0, sl1_r};
        `RD_SL2: o_readdata <= {12'h0, sl2_r};
        `RD_EV_MASK: o_readdata <= {24'h0, ev_mask_r};
        `RD_STATUS: o_readdata <= {28'h0, pick_r, o_condition, block_s_r};
        `RD_TRIP_CNT: o_readdata <= {16'h0, trip_cnt_r};
        `RD_BLOCK_CNT: o_readdata <= {16'h0, block_cnt_r};
        `RD_REC_SEL: o_readdata <= {28'h0, rec_sel_r};
        `RD_REC_NUM: o_readdata <= {28'h0, rec_num_r};
        8'h30: o_readdata <= rec_rd.stamp;
        8'h34: o_readdata <= {30'h0, rec_rd.event_id};
        8'h38: o_readdata <= {8'h0, rec_rd.bias};
        8'h3c: o_readdata <= {8'h0, rec_rd.diff};
        8'h40: o_readdata <= {8'h0, rec_rd.thr};
        8'h44: o_readdata <= {8'h0, rec_rd.bias_max};
        8'h48: o_readdata <= {8'h0, rec_rd.diff_max};
        8'h4c: o_readdata <= {8'h0, rec_rd.thr_max};
        8'h50: o_readdata <= {8'h0, rec_rd.calc};
        8'h54: o_readdata <= {8'h0, rec_rd.meas};
        `RD_REC_LAST: o_readdata <= {29'h0, rec_rd.group};
        `RD_TIME_MS: o_readdata <= time_ms_r;
        default: o_readdata <= 32'h0;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  sequence s_pick_free;
    valid_a_r && pick && !block_s_r && !ctrl_r[`CTRL_FORCE_EN];
  endsequence
  sequence s_pick_held;
    valid_a_r && pick && block_s_r && !ctrl_r[`CTRL_FORCE_EN];
  endsequence
  a_trip_on_pick: assert property (s_pick_free |=> o_trip && !o_blocked)
    else $error("trip missing after unblocked pick-up");
  a_block_on_pick: assert property (s_pick_held |=> o_blocked && !o_trip)
    else $error("blocked missing after blocked pick-up");
  a_trip_drops_block: assert property (o_trip ##0 s_pick_held |=> !o_trip)
    else $error("trip held although block arrived");
  a_block_sampled: assert property (i_sample |=> block_s_r == $past(i_block))
    else $error("block not sampled at cycle start");
  a_pick_threshold: assert property (valid_a_r && diff_mag <= thr |=> !pick_r)
    else $error("pick-up without threshold exceeded");
  a_thr_base: assert property (bias < 24'(tp1_r) |-> thr == 24'(pickup_r))
    else $error("threshold below first turn point wrong");
  a_cond_trip: assert property (o_trip && !ctrl_r[`CTRL_FORCE_EN] |-> o_condition == 2'(cond_trip))
    else $error("condition disagrees with trip");
  a_force_gate: assert property (valid_a_r && !ctrl_r[`CTRL_FORCE_EN] && !pick |=> !o_trip && !o_blocked)
    else $error("output active with no pick-up and no forcing");
  a_count_trip: assert property (ev_new[0] && !cnt_clr_r |=> trip_cnt_r == $past(trip_cnt_r) + 16'h1)
    else $error("trip counter missed an occurrence");
  a_rec_wrap: assert property ((ev_new[0] || ev_new[2]) && rec_head_r == 4'd11 |=> rec_head_r == 4'h0)
    else $error("record store did not wrap after twelve");
  a_event_stamp: assert property (|ev_send |=> o_event_valid && o_event_stamp == $past(time_ms_r))
    else $error("event not emitted with time stamp");
  a_bus_answer: assert property ((i_read || i_write) && o_waitrequest && !req_done_r |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus answer not one cycle wide");
endmodule : residual_diff_stage
